// file: rtl/tlic_pkg.sv
/*
 * tlic_pkg: shared constants of the two-level interrupt controller.
 * Assumes the register port of the top module, word addresses as given here.
 */
package tlic_pkg;
    localparam int          NUM_SRC        = 32;
    localparam int          PRIO_W         = 5;
    // register addresses (word index on the plain register port)
    localparam logic [7:0]  ADDR_L1_MASK   = 8'h00;
    localparam logic [7:0]  ADDR_L1_STAT   = 8'h01;
    localparam logic [7:0]  ADDR_L2_MASK   = 8'h02;
    localparam logic [7:0]  ADDR_L2_PEND   = 8'h03;
    localparam logic [7:0]  ADDR_SRC_CODE  = 8'h04;
    localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h05;
    localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h06;
    localparam logic [7:0]  ADDR_LEVEL0    = 8'h20;
    // level register field positions
    localparam int          LVL_ROUTE_BIT  = 0;
    localparam int          LVL_SENS_BIT   = 1;
    localparam int          LVL_PRIO_LSB   = 2;
    // reset values, and the source code read when no source is active
    localparam logic [31:0] MASK_RST       = 32'hffff_ffff;
    localparam logic [31:0] LEVEL_RST      = 32'h0000_0000;
    localparam logic [1:0]  IRQ_MASK_RST   = 2'h3;
    localparam logic [31:0] NONE_CODE      = 32'h0000_0080;
    // status event bits: new unmasked second-level request, source-code read
    localparam int          EV_NEW_REQ     = 0;
    localparam int          EV_ACK         = 1;
endpackage : tlic_pkg

// file: rtl/tlic_arbiter.sv
/*
 * tlic_arbiter: picks the pending unmasked source with the lowest priority value.
 * Assumes pending, mask and level words arrive from the same clock domain.
 */
module tlic_arbiter #(
    parameter int NUM_SRC = 32,
    parameter int PRIO_W  = 5
) (
    input  wire logic [NUM_SRC-1:0]        req,
    input  wire logic [NUM_SRC*PRIO_W-1:0] prio,
    output logic                           any,
    output logic [$clog2(NUM_SRC)-1:0]     winner
);
    // linear scan; strict less-than keeps ties on the lower input number
    always_comb begin
        logic [PRIO_W-1:0] best;
        best   = '1;
        any    = 1'b0;
        winner = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (req[i] && (!any || prio[i*PRIO_W +: PRIO_W] < best)) begin
                any    = 1'b1;
                best   = prio[i*PRIO_W +: PRIO_W];
                winner = i[$clog2(NUM_SRC)-1:0];
            end
        end
    end
endmodule : tlic_arbiter

// file: rtl/tlic_top.sv
/*
 * tlic_top: two-level interrupt controller with register port and
 * normal/fast interrupt outputs to the processor.
 * Holds the second-level pending, mask and level registers, the priority
 * arbiter instance, the first-level gate and the event status block.
 * Word map: 00 first-level mask, 01 first-level raw status, 02 second-level
 * mask, 03 pending, 04 source code, 05 event status, 06 event mask,
 * 20 onwards one level register per second-level input.
 * Assumes source inputs arrive asynchronously and are synchronised here;
 * the register port runs on mclk with read data one cycle after the strobe.
 */
// Added by the designer: the register addresses and the strobed register port.
module tlic_top #(
    parameter int NUM_SRC = tlic_pkg::NUM_SRC,
    parameter int PRIO_W  = tlic_pkg::PRIO_W
) (
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire logic [NUM_SRC-1:0] src_in,
    input  wire logic [31:1]        l1_src_in,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [31:0]        reg_rdata,
    output logic                    irq_line,
    output logic                    fast_interrupt_line,
    output logic                    ctrl_irq
);
    localparam int IDX_W = $clog2(NUM_SRC);

    // parameter limits that the arbiter and 32-bit register words can serve
    initial begin
        if (NUM_SRC < 2)
            $error("tlic_top: NUM_SRC below 2");
        if (NUM_SRC > 32)
            $error("tlic_top: NUM_SRC above register width");
        if (PRIO_W < 1)
            $error("tlic_top: PRIO_W below 1");
        if (PRIO_W > 5)
            $error("tlic_top: PRIO_W wider than priority field");
    end

    // level register helpers
    function automatic logic lvl_edge(input logic [31:0] lvl);
        return lvl[tlic_pkg::LVL_SENS_BIT] == 1'b0;
    endfunction : lvl_edge

    function automatic logic lvl_fast(input logic [31:0] lvl);
        return lvl[tlic_pkg::LVL_ROUTE_BIT];
    endfunction : lvl_fast

    // address decode of the level register of input idx
    function automatic logic lvl_hit(input logic [7:0] addr, input int idx);
        return addr == tlic_pkg::ADDR_LEVEL0 + 8'(idx);
    endfunction : lvl_hit

    // input synchronisers
    logic [NUM_SRC-1:0] src_s1;
    logic [NUM_SRC-1:0] src_s2;
    logic [NUM_SRC-1:0] src_prev;
    logic [31:1]        l1_s1;
    logic [31:1]        l1_s2;
    logic [NUM_SRC-1:0] next_src_s1;
    logic [NUM_SRC-1:0] next_src_s2;
    logic [NUM_SRC-1:0] next_src_prev;
    logic [31:1]        next_l1_s1;
    logic [31:1]        next_l1_s2;
    // two-stage chains; the second stage feeds logic, and for sources also the src_prev copy of it
    always_comb begin
        next_src_s1   = src_in;
        next_src_s2   = src_s1;
        next_src_prev = src_s2;
        next_l1_s1    = l1_src_in;
        next_l1_s2    = l1_s1;
    end
    // registers of the synchroniser chains
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            src_s1   <= '0;
            src_s2   <= '0;
            src_prev <= '0;
            l1_s1    <= '0;
            l1_s2    <= '0;
        end else begin
            src_s1   <= next_src_s1;
            src_s2   <= next_src_s2;
            src_prev <= next_src_prev;
            l1_s1    <= next_l1_s1;
            l1_s2    <= next_l1_s2;
        end
    end

    // register state
    logic [31:0]        mask_register;
    logic [NUM_SRC-1:0] l2_mask;
    logic [NUM_SRC-1:0] pending_input_register;
    logic [31:0]        level [NUM_SRC];
    logic [1:0]         irq_stat;
    logic [1:0]         irq_mask;
    logic [31:0]        next_mask_register;
    logic [NUM_SRC-1:0] next_l2_mask;
    logic [NUM_SRC-1:0] next_pending;
    logic [31:0]        next_level [NUM_SRC];
    logic [1:0]         next_irq_stat;
    logic [1:0]         next_irq_mask;

    // arbitration over pending, unmasked sources
    logic [NUM_SRC-1:0]        l2_active;
    logic [NUM_SRC*PRIO_W-1:0] prio_vec;
    logic                      l2_any;
    logic [IDX_W-1:0]          l2_win;
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            l2_active[i] = pending_input_register[i] && !l2_mask[i];
            prio_vec[i*PRIO_W +: PRIO_W] =
                level[i][tlic_pkg::LVL_PRIO_LSB +: PRIO_W];
        end
    end

    tlic_arbiter #(
        .NUM_SRC (NUM_SRC),
        .PRIO_W  (PRIO_W)
    ) u_arb (
        .req    (l2_active),
        .prio   (prio_vec),
        .any    (l2_any),
        .winner (l2_win)
    );

    // decode of register port
    logic wr_l1_mask;
    logic wr_l2_mask;
    logic wr_pend;
    logic wr_istat;
    logic wr_imask;
    logic rd_code;
    logic new_req;
    always_comb begin
        wr_l1_mask = reg_wr && reg_addr == tlic_pkg::ADDR_L1_MASK;
        wr_l2_mask = reg_wr && reg_addr == tlic_pkg::ADDR_L2_MASK;
        wr_pend    = reg_wr && reg_addr == tlic_pkg::ADDR_L2_PEND;
        wr_istat   = reg_wr && reg_addr == tlic_pkg::ADDR_IRQ_STAT;
        wr_imask   = reg_wr && reg_addr == tlic_pkg::ADDR_IRQ_MASK;
        rd_code    = reg_rd && reg_addr == tlic_pkg::ADDR_SRC_CODE;
        new_req    = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (!l2_mask[i] && src_s2[i] && (!lvl_edge(level[i]) || !src_prev[i]))
                new_req = new_req || !pending_input_register[i];
        end
    end

    // per-input request conditions after the synchronisers
    logic [NUM_SRC-1:0] src_rise;
    logic [NUM_SRC-1:0] edge_mode;
    logic [NUM_SRC-1:0] clr_by_wr;
    logic [NUM_SRC-1:0] clr_by_code;
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            src_rise[i]    = src_s2[i] && !src_prev[i];
            edge_mode[i]   = lvl_edge(level[i]);
            clr_by_wr[i]   = wr_pend && !reg_wdata[i];
            clr_by_code[i] = rd_code && l2_any && l2_win == IDX_W'(i);
        end
    end

    // next values of masks and level registers
    always_comb begin
        next_mask_register = mask_register;
        next_l2_mask       = l2_mask;
        for (int i = 0; i < NUM_SRC; i++)
            next_level[i] = level[i];
        if (wr_l1_mask)
            next_mask_register = reg_wdata;
        if (wr_l2_mask)
            next_l2_mask = reg_wdata[NUM_SRC-1:0];
        for (int i = 0; i < NUM_SRC; i++) begin
            if (reg_wr && lvl_hit(reg_addr, i))
                next_level[i] = reg_wdata;
        end
    end

    // configuration registers; everything masked out of reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mask_register <= tlic_pkg::MASK_RST;
            l2_mask       <= NUM_SRC'(tlic_pkg::MASK_RST);
            for (int i = 0; i < NUM_SRC; i++)
                level[i] <= tlic_pkg::LEVEL_RST;
        end else begin
            mask_register <= next_mask_register;
            l2_mask       <= next_l2_mask;
            for (int i = 0; i < NUM_SRC; i++)
                level[i] <= next_level[i];
        end
    end

    // next pending bits; clears first, so a new event in the same cycle wins
    always_comb begin
        next_pending = pending_input_register;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (clr_by_wr[i])
                next_pending[i] = 1'b0;
            if (clr_by_code[i])
                next_pending[i] = 1'b0;
            if (edge_mode[i]) begin
                if (src_rise[i])
                    next_pending[i] = 1'b1;
            end else if (src_s2[i]) begin
                next_pending[i] = 1'b1;
            end else if (!clr_by_wr[i]) begin
                next_pending[i] = 1'b0;
            end
        end
    end

    // pending register; level inputs follow their source
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            pending_input_register <= '0;
        else
            pending_input_register <= next_pending;
    end

    // next event status and mask; a set event beats a same-cycle clear
    always_comb begin
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        if (wr_imask)
            next_irq_mask = reg_wdata[1:0];
        if (wr_istat)
            next_irq_stat = irq_stat & ~reg_wdata[1:0];
        if (new_req)
            next_irq_stat[tlic_pkg::EV_NEW_REQ] = 1'b1;
        if (rd_code)
            next_irq_stat[tlic_pkg::EV_ACK] = 1'b1;
    end

    // event status and mask registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= tlic_pkg::IRQ_MASK_RST;
            irq_stat <= '0;
        end else begin
            irq_mask <= next_irq_mask;
            irq_stat <= next_irq_stat;
        end
    end

    // first level: input 0 is the second-level summary, others from pins
    logic [31:0] l1_raw;
    logic [31:0] l1_live;
    logic        next_irq_line;
    logic        next_fast;
    logic        next_ctrl_irq;
    logic [31:0] next_src_code;
    logic [31:0] next_rdata;
    always_comb begin
        l1_raw        = {l1_s2, l2_any};
        next_irq_line = 1'b0;
        next_fast     = 1'b0;
        l1_live       = l1_raw & ~mask_register;
        if (l1_live[0]) begin
            if (lvl_fast(level[l2_win]))
                next_fast = 1'b1;
            else
                next_irq_line = 1'b1;
        end
        // other first-level inputs go to the normal line
        if (l1_live[31:1] != 31'h0)
            next_irq_line = 1'b1;
        next_ctrl_irq = (irq_stat & ~irq_mask) != 2'h0;
        next_src_code = l2_any ? 32'(l2_win) : tlic_pkg::NONE_CODE;
    end

    // read mux; data stand only in the cycle after the strobe
    always_comb begin
        unique case (reg_addr)
            tlic_pkg::ADDR_L1_MASK:  next_rdata = mask_register;
            tlic_pkg::ADDR_L1_STAT:  next_rdata = l1_raw;
            tlic_pkg::ADDR_L2_MASK:  next_rdata = 32'(l2_mask);
            tlic_pkg::ADDR_L2_PEND:  next_rdata = 32'(pending_input_register);
            tlic_pkg::ADDR_SRC_CODE: next_rdata = next_src_code;
            tlic_pkg::ADDR_IRQ_STAT: next_rdata = 32'(irq_stat);
            tlic_pkg::ADDR_IRQ_MASK: next_rdata = 32'(irq_mask);
            default: begin
                next_rdata = 32'h0;
                for (int i = 0; i < NUM_SRC; i++)
                    if (lvl_hit(reg_addr, i))
                        next_rdata = level[i];
            end
        endcase
        if (!reg_rd)
            next_rdata = 32'h0;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_line            <= 1'b0;
            fast_interrupt_line <= 1'b0;
            ctrl_irq            <= 1'b0;
            reg_rdata           <= '0;
        end else begin
            irq_line            <= next_irq_line;
            fast_interrupt_line <= next_fast;
            ctrl_irq            <= next_ctrl_irq;
            reg_rdata           <= next_rdata;
        end
    end
endmodule : tlic_top

// file: tb/tlic_props.sv
/* tlic_props: port checker for tlic_top.
   assumes bind to tlic_top, one clock mclk, async reset rst_n */
module tlic_props #(
    parameter int NUM_SRC = 32
) (
    input wire logic               mclk,
    input wire logic               rst_n,
    input wire logic [NUM_SRC-1:0] src_in,
    input wire logic [31:1]        l1_src_in,
    input wire logic [7:0]         reg_addr,
    input wire logic [31:0]        reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [31:0]        reg_rdata,
    input wire logic               irq_line,
    input wire logic               fast_interrupt_line
);
    logic [3:0] quiet;
    logic [3:0] idle;
    logic       fast_seen;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // quiet-source and idle counters, history of fast routing
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            quiet     <= 4'h0;
            idle      <= 4'h0;
            fast_seen <= 1'b0;
        end else begin
            quiet     <= (|src_in) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
            idle      <= (|src_in || |l1_src_in || reg_wr || reg_rd) ? 4'h0
                         : idle + {3'h0, idle != 4'hf};
            fast_seen <= fast_seen | (reg_wr & (reg_addr >= 8'h20) & reg_wdata[0]);
        end
    end
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
    property p_code_range;
        reg_rd && reg_addr == 8'h04 |=> reg_rdata < NUM_SRC || reg_rdata == 32'h80;
    endproperty
    a_code_range: assert property (p_code_range) else $error("bad source code");
    property p_l1_mask_off;
        reg_wr && reg_addr == 8'h00 && reg_wdata == 32'hffff_ffff ##1 !reg_wr [*3]
            |-> !irq_line && !fast_interrupt_line;
    endproperty
    a_l1_mask_off: assert property (p_l1_mask_off) else $error("line despite mask");
    property p_l2_mask_off;
        reg_wr && reg_addr == 8'h02 && reg_wdata == 32'hffff_ffff ##1 !reg_wr [*3]
            |-> !fast_interrupt_line;
    endproperty
    a_l2_mask_off: assert property (p_l2_mask_off) else $error("fast despite mask");
    property p_pend_clear;
        reg_wr && reg_addr == 8'h03 && reg_wdata == 32'h0 && quiet > 4'h4
            ##2 reg_rd && reg_addr == 8'h03 && quiet > 4'h6 |=> reg_rdata == 32'h0;
    endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("pending not cleared");
    property p_fast_route;
        !fast_seen |-> !fast_interrupt_line;
    endproperty
    a_fast_route: assert property (p_fast_route) else $error("fast without route");
    property p_irq_cause;
        $rose(irq_line) |-> idle < 4'h7;
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
    property p_unmapped;
        reg_rd && reg_addr inside {[8'h07:8'h1f]} |=> reg_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : tlic_props
bind tlic_top tlic_props #(.NUM_SRC(NUM_SRC)) u_props (.mclk(mclk), .rst_n(rst_n),
    .src_in(src_in), .l1_src_in(l1_src_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_line(irq_line),
    .fast_interrupt_line(fast_interrupt_line));

// file: tb/tlic_cpu_model.sv
/* tlic_cpu_model: processor software on the register port.
   assumes the tlic_pkg map, read data one cycle after the strobe */
module tlic_cpu_model (
    input  wire logic        mclk,
    output logic      [7:0]  reg_addr,
    output logic      [31:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd
);
    logic [31:0] l2m;
    // idle bus, all inputs masked
    initial begin
        reg_addr  = 8'h0;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        l2m       = 32'hffff_ffff;
    end
    // one write cycle, data scrambled once released
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    // one read cycle, answer taken by the bench monitor
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
    endtask : rd
    // clear stale request, set level, then unmask
    task automatic setup(input int n, input logic [31:0] lvl);
        wr(tlic_pkg::ADDR_L2_PEND, ~(32'h1 << n));
        wr(tlic_pkg::ADDR_LEVEL0 + 8'(n), lvl);
        l2m[n] = 1'b0;
        wr(tlic_pkg::ADDR_L2_MASK, l2m);
    endtask : setup
    // first-level handler fetches the active source
    task automatic service();
        rd(tlic_pkg::ADDR_SRC_CODE);
    endtask : service
endmodule : tlic_cpu_model

// file: tb/testbench.sv
/* testbench: self-checking bench for tlic_top.
   assumes tlic_cpu_model as processor, checker bound to tlic_top */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [31:0] src_in = 32'h0;
    logic [31:1] l1_src_in = 31'h0;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic        reg_wr, reg_rd, irq_line, fast_interrupt_line, ctrl_irq;
    logic        rd_d = 1'b0;
    logic        peek = 1'b0;
    logic [31:0] exp_q[$];
    string       name_q[$];
    int          num_errors = 0;
    int          num_checks = 0;
    logic [4:0]  p3, p5;
    int          k;
    always #4 mclk = ~mclk;
    tlic_top dut (.mclk(mclk), .rst_n(rst_n), .src_in(src_in), .l1_src_in(l1_src_in),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq_line(irq_line),
        .fast_interrupt_line(fast_interrupt_line), .ctrl_irq(ctrl_irq));
    tlic_cpu_model cpu (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    task automatic note(logic [31:0] e, string nm);
        exp_q.push_back(e);
        name_q.push_back(nm);
    endtask : note
    task automatic rd_chk(logic [7:0] a, logic [31:0] e, string nm);
        note(e, nm);
        cpu.rd(a);
    endtask : rd_chk
    // sample ctrl, fast and normal lines once
    task automatic lines(logic [2:0] e, string nm);
        note({29'h0, e}, nm);
        @(posedge mclk);
        peek <= 1'b1;
        @(posedge mclk);
        peek <= 1'b0;
    endtask : lines
    task automatic pulse(int n);
        @(posedge mclk);
        src_in[n] <= 1'b1;
        repeat (2) @(posedge mclk);
        src_in[n] <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask : pulse
    // monitor: oldest note against each read answer or line sample
    always @(posedge mclk) begin
        if (rd_d) check(name_q.pop_front(), reg_rdata, exp_q.pop_front());
        if (peek) check(name_q.pop_front(), {29'h0, ctrl_irq, fast_interrupt_line, irq_line},
            exp_q.pop_front());
        rd_d <= reg_rd;
    end
    // watchdog
    initial begin
        repeat (3000) @(posedge mclk);
        num_errors++;
        $display("watchdog expired");
        stop_test();
    end
    // main sequence
    initial begin
        void'($urandom(32'hfe3f5480));
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        rd_chk(8'h00, 32'hffff_ffff, "l1 mask");
        rd_chk(8'h02, 32'hffff_ffff, "l2 mask");
        rd_chk(8'h03, 32'h0, "pending");
        rd_chk(8'h04, 32'h80, "idle code");
        rd_chk(8'h06, 32'h3, "event mask");
        rd_chk(8'h10, 32'h0, "unmapped");
        rd_chk(8'h2c, 32'h0, "level12");
        $display("reset test done");
        cpu.setup(12, 32'h0);
        cpu.wr(8'h00, 32'hffff_fffe);
        pulse(12);
        lines(3'b001, "edge irq");
        rd_chk(8'h03, 32'h1000, "latched");
        note(32'hc, "code12");
        cpu.service();
        lines(3'b000, "after code read");
        pulse(12);
        cpu.wr(8'h03, 32'h0);
        rd_chk(8'h03, 32'h0, "pend cleared");
        lines(3'b000, "cleared line");
        cpu.wr(8'h2c, 32'h1);
        pulse(12);
        lines(3'b010, "fast route");
        note(32'hc, "fast code");
        cpu.service();
        $display("edge test done");
        cpu.wr(8'h2c, 32'h2);
        @(posedge mclk);
        src_in[12] <= 1'b1;
        repeat (6) @(posedge mclk);
        lines(3'b001, "level high");
        src_in[12] <= 1'b0;
        repeat (6) @(posedge mclk);
        lines(3'b000, "level gone");
        $display("level test done");
        p3 = 5'($urandom_range(31, 1));
        p5 = p3 - 5'($urandom_range(1, 0));
        cpu.setup(3, {25'h0, p3, 2'b00});
        cpu.setup(5, {25'h0, p5, 2'b00});
        @(posedge mclk);
        src_in[5] <= 1'b1;
        pulse(3);
        src_in[5] <= 1'b0;
        note((p5 < p3) ? 32'h5 : 32'h3, "first winner");
        cpu.service();
        note((p5 < p3) ? 32'h3 : 32'h5, "second winner");
        cpu.service();
        rd_chk(8'h04, 32'h80, "none left");
        $display("priority test done");
        cpu.wr(8'h00, 32'hffff_ffff);
        pulse(3);
        lines(3'b000, "l1 masked");
        cpu.wr(8'h00, 32'hffff_fffe);
        lines(3'b001, "l1 unmasked");
        cpu.wr(8'h02, 32'hffff_ffff);
        lines(3'b000, "l2 masked");
        $display("mask test done");
        cpu.wr(8'h02, 32'hffff_efff);
        cpu.wr(8'h05, 32'h3);
        cpu.wr(8'h06, 32'h0);
        @(posedge mclk);
        src_in[12] <= 1'b1;
        repeat (6) @(posedge mclk);
        lines(3'b101, "event raised");
        rd_chk(8'h05, 32'h1, "event status");
        src_in[12] <= 1'b0;
        cpu.wr(8'h05, 32'h1);
        repeat (4) @(posedge mclk);
        lines(3'b000, "event cleared");
        k = $urandom_range(31, 1);
        l1_src_in[k] <= 1'b1;
        cpu.wr(8'h00, ~(32'h1 << k));
        repeat (4) @(posedge mclk);
        lines(3'b001, "other l1 input");
        rd_chk(8'h01, 32'h1 << k, "l1 status");
        $display("event test done");
        stop_test();
    end
endmodule : testbench
